// file: rtl/pba_target.sv
// Device end of the PCI link: a target with configuration and memory words.
// Assumes the host end on pba_if.dev and a free-running link clock far below CLK_SYS.
//
// Summary of operation
// - Address with frame start, then data
// - Command in address phase, byte enables after
// - Parity is even over AD and PAR
// - Address/write parity by master, read by target
// - Frame starts transaction, release marks last datum
// - Target ready shows target can complete
// - Initiator ready shows master can complete
// - Stop from target makes master terminate
// - Receiver flags data parity two clocks later
// - System error on address or special parity
// - Everything but link reset happens on link clock rising edges
// - Select input taken from request two pin
// - Select line marks configuration access to device
// - Decoding target claims with device select
// - Link reset clears all link logic
`timescale 1ns/1ps
`include "pba_params.svh"
module pba_target (
	input  wire logic CLK_SYS,
	input  wire logic SRST,
	input  wire logic CE,
	pba_if.dev        p,
	output logic      BUSY,
	output logic      ADDR_PERR,
	output logic      DATA_PERR
);
	import pba_pkg::*;

	pba_tgt_s q;
	pba_tgt_s n;

	assign p.dd      = q.dd;
	assign BUSY      = q.busy;
	assign ADDR_PERR = q.aperr;
	assign DATA_PERR = q.dperr;

	always_comb begin
		pba_bus_s    b;
		logic [31:0] w;
		logic [3:0]  nxt;
		logic        hit;
		n   = q;
		b   = q.s2;
		w   = 32'h0;
		nxt = 4'h0;
		hit = 1'b0;
		// Both the link clock and every lane pass two flops, so they stay aligned.
		n.s1    = p.bus;
		n.s2    = q.s1;
		n.clk_q = q.s2.clk;
		n.aperr = 1'b0;
		n.dperr = 1'b0;
		if (!b.rst_n) begin
			n.st       = T_IDLE;
			n.dd       = `PBA_DRV_OFF;
			n.fr_q     = 1'b0;
			n.addr_chk = 1'b0;
			n.data_chk = 1'b0;
			n.perr_st  = 2'h0;
			n.serr     = 1'b0;
			n.spec     = 1'b0;
			n.busy     = 1'b0;
			n.cfg_m    = '0;
			n.mem_m    = '0;
		end else if (b.clk && !q.clk_q) begin
			n.fr_q = b.ctl[`PBA_FRAME];
			// Parity follows the lanes this end drove one link clock earlier.
			n.dd.ctl_o[`PBA_PAR]    = ^q.dd.ad_o;
			n.dd.ctl_oe_n[`PBA_PAR] = q.dd.ad_oe_n;
			n.addr_chk = 1'b0;
			n.data_chk = 1'b0;
			n.serr     = 1'b0;
			n.perr_st  = (q.perr_st == 2'h1) ? 2'h2 : 2'h0;
			if (q.addr_chk && ^{q.ad_q, b.ctl[`PBA_PAR]}) begin
				n.serr  = 1'b1;
				n.aperr = 1'b1;
			end
			if (q.data_chk && ^{q.ad_q, b.ctl[`PBA_PAR]}) begin
				n.dperr = 1'b1;
				if (q.spec) begin
					n.serr = 1'b1;
				end else begin
					n.perr_st = 2'h1;
				end
			end
			unique case (q.st)
				T_IDLE: begin
					if (!b.ctl[`PBA_FRAME] && q.fr_q) begin
						n.ad_q     = b.ad;
						n.addr_chk = 1'b1;
						n.spec     = (b.cbe == `PBA_CMD_SPEC);
						n.cfg      = (b.cbe[3:1] == `PBA_GRP_CFG) && b.idsel;
						hit        = n.cfg || ((b.cbe[3:1] == `PBA_GRP_MEM)
							&& (b.ad[31:6] == `PBA_MEM_BASE));
						n.wr       = b.cbe[0];
						n.idx      = b.ad[5:2];
						n.wcnt     = `PBA_TGT_WAIT;
						if (hit) begin
							n.st                       = T_WAIT;
							n.dd.ctl_o[`PBA_DEVSEL]    = 1'b0;
							n.dd.ctl_o[`PBA_TRDY]      = 1'b1;
							n.dd.ctl_o[`PBA_STOP]      = 1'b1;
							n.dd.ctl_oe_n[`PBA_DEVSEL] = 1'b0;
							n.dd.ctl_oe_n[`PBA_TRDY]   = 1'b0;
							n.dd.ctl_oe_n[`PBA_STOP]   = 1'b0;
						end else if (n.spec) begin
							n.st = T_SPEC;
						end
					end
				end
				T_WAIT: begin
					// The wait clock also gives the turnaround the host needs to release AD.
					if (q.wcnt != 2'h0) begin
						n.wcnt = q.wcnt - 2'h1;
					end else begin
						n.st                  = T_DATA;
						n.dd.ctl_o[`PBA_TRDY] = 1'b0;
						n.dd.ctl_o[`PBA_STOP] = (q.idx != `PBA_LAST_IDX);
						if (!q.wr) begin
							n.dd.ad_o    = q.cfg ? q.cfg_m[q.idx] : q.mem_m[q.idx];
							n.dd.ad_oe_n = 1'b0;
						end
					end
				end
				T_DATA: begin
					if (!b.ctl[`PBA_IRDY] && !b.ctl[`PBA_TRDY]) begin
						if (q.wr) begin
							w = q.cfg ? q.cfg_m[q.idx] : q.mem_m[q.idx];
							for (int i = 0; i < 4; i++) begin
								if (!b.cbe[i]) begin
									w[8*i +: 8] = b.ad[8*i +: 8];
								end
							end
							if (q.cfg) begin
								n.cfg_m[q.idx] = w;
							end else begin
								n.mem_m[q.idx] = w;
							end
							n.ad_q     = b.ad;
							n.data_chk = 1'b1;
						end
						nxt   = q.idx + 4'h1;
						n.idx = nxt;
						if (b.ctl[`PBA_FRAME]) begin
							n.st                    = T_TURN;
							n.dd.ctl_o[`PBA_TRDY]   = 1'b1;
							n.dd.ctl_o[`PBA_STOP]   = 1'b1;
							n.dd.ctl_o[`PBA_DEVSEL] = 1'b1;
							n.dd.ad_oe_n            = 1'b1;
						end else if (!q.dd.ctl_o[`PBA_STOP]) begin
							n.st                  = T_STOP;
							n.dd.ctl_o[`PBA_TRDY] = 1'b1;
							n.dd.ad_oe_n          = 1'b1;
						end else begin
							n.dd.ctl_o[`PBA_STOP] = (nxt != `PBA_LAST_IDX);
							if (!q.wr) begin
								n.dd.ad_o = q.cfg ? q.cfg_m[nxt] : q.mem_m[nxt];
							end
						end
					end
				end
				T_STOP: begin
					// Stop stays asserted until the host shows its final phase.
					if (b.ctl[`PBA_FRAME]) begin
						n.st                    = T_TURN;
						n.dd.ctl_o[`PBA_STOP]   = 1'b1;
						n.dd.ctl_o[`PBA_DEVSEL] = 1'b1;
					end
				end
				T_TURN: begin
					n.st                       = T_IDLE;
					n.dd.ctl_oe_n[`PBA_TRDY]   = 1'b1;
					n.dd.ctl_oe_n[`PBA_STOP]   = 1'b1;
					n.dd.ctl_oe_n[`PBA_DEVSEL] = 1'b1;
				end
				T_SPEC: begin
					// Nobody claims a special cycle, so the data is taken when the host is ready.
					if (!b.ctl[`PBA_IRDY]) begin
						n.ad_q     = b.ad;
						n.data_chk = 1'b1;
						n.st       = T_IDLE;
					end else if (b.ctl[`PBA_FRAME]) begin
						n.st = T_IDLE;
					end
				end
				// Two state codes are unused; a stray one falls back to idle.
				default: begin
					n.st = T_IDLE;
				end
			endcase
			n.dd.ctl_oe_n[`PBA_PERR] = (n.perr_st == 2'h0);
			n.dd.ctl_o[`PBA_PERR]    = (n.perr_st != 2'h1);
			n.dd.ctl_oe_n[`PBA_SERR] = !n.serr;
			n.busy                   = (n.st != T_IDLE);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			q    <= '0;
			q.dd <= `PBA_DRV_OFF;
		end else if (CE) begin
			q <= n;
		end
	end
endmodule

// file: rtl/pba_params.svh
// Constants shared by both ends of the PCI bus agent link.
// Assumes it is included by bare name from the design files.
`ifndef PBA_PARAMS_SVH
`define PBA_PARAMS_SVH
// Bit positions inside the single-bit control pin vector.
`define PBA_PAR        0
`define PBA_FRAME      1
`define PBA_IRDY       2
`define PBA_TRDY       3
`define PBA_STOP       4
`define PBA_DEVSEL     5
`define PBA_PERR       6
`define PBA_SERR       7
// Released drive word: no lane driven, open-drain error line held at zero.
`define PBA_DRV_OFF    {32'h0, 1'h1, 4'h0, 1'h1, 8'h7F, 8'hFF}
// Bus commands and command groups.
`define PBA_CMD_SPEC   4'h1
`define PBA_GRP_MEM    3'h3
`define PBA_GRP_CFG    3'h5
// Memory window of the device end, compared against address bits 31:6.
`define PBA_MEM_BASE   26'h0040000
`define PBA_LAST_IDX   4'hF
// Target wait clocks before ready, master abort limit in link clocks.
`define PBA_TGT_WAIT   2'h1
`define PBA_ABORT_CLKS 3'h5
// Completion status bits of the host end.
`define PBA_ST_STOP    0
`define PBA_ST_ABORT   1
`define PBA_ST_PERR    2
`endif

// file: rtl/pba_pkg.sv
// Types shared by both ends of the PCI bus agent link.
// Assumes pba_params.svh supplies the constants.
package pba_pkg;
	typedef struct packed {
		logic [31:0] ad_o;
		logic        ad_oe_n;
		logic [3:0]  cbe_o;
		logic        cbe_oe_n;
		logic [7:0]  ctl_o;
		logic [7:0]  ctl_oe_n;
	} pba_drv_s;
	typedef struct packed {
		logic        clk;
		logic        rst_n;
		logic        idsel;
		logic [31:0] ad;
		logic [3:0]  cbe;
		logic [7:0]  ctl;
	} pba_bus_s;
	typedef enum logic [2:0] {T_IDLE, T_WAIT, T_DATA, T_STOP, T_TURN, T_SPEC} pba_tst_e;
	typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pba_mst_e;
	typedef struct packed {
		pba_bus_s           s1;
		pba_bus_s           s2;
		logic               clk_q;
		logic               fr_q;
		pba_tst_e           st;
		logic [3:0]         idx;
		logic               wr;
		logic               cfg;
		logic               spec;
		logic [1:0]         wcnt;
		logic               addr_chk;
		logic               data_chk;
		logic [31:0]        ad_q;
		logic [1:0]         perr_st;
		logic               serr;
		logic               busy;
		logic               aperr;
		logic               dperr;
		pba_drv_s           dd;
		logic [15:0][31:0]  cfg_m;
		logic [15:0][31:0]  mem_m;
	} pba_tgt_s;
	typedef struct packed {
		pba_bus_s    s1;
		pba_bus_s    s2;
		logic        clk_q;
		pba_mst_e    st;
		logic [3:0]  cmd;
		logic [3:0]  be;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [2:0]  left;
		logic        idsel;
		logic        idsel_o;
		logic [2:0]  cnt;
		logic        dsel;
		logic        data_chk;
		logic [31:0] ad_q;
		logic [1:0]  perr_st;
		logic        rst_n;
		logic        rdy;
		logic        rsp_v;
		logic [31:0] rsp_d;
		logic        done;
		logic [2:0]  stat;
		pba_drv_s    hd;
	} pba_hst_s;
endpackage

// file: rtl/pba_if.sv
// Shared PCI wires between the device end and the host end.
// Assumes the bench drives clk; pull-ups are modelled as released lanes reading one.
`timescale 1ns/1ps
interface pba_if;
	import pba_pkg::*;
	logic     clk;
	logic     rst_n;
	logic     idsel;
	pba_drv_s hd;
	pba_drv_s dd;
	pba_bus_s bus;
	// Every lane is a wired AND of both ends, which also covers the open-drain error line.
	assign bus.clk   = clk;
	assign bus.rst_n = rst_n;
	assign bus.idsel = idsel;
	assign bus.ad    = (hd.ad_o | {32{hd.ad_oe_n}}) & (dd.ad_o | {32{dd.ad_oe_n}});
	assign bus.cbe   = (hd.cbe_o | {4{hd.cbe_oe_n}}) & (dd.cbe_o | {4{dd.cbe_oe_n}});
	assign bus.ctl   = (hd.ctl_o | hd.ctl_oe_n) & (dd.ctl_o | dd.ctl_oe_n);
	modport dev (input bus, output dd);
	modport host (input bus, output hd, output rst_n, output idsel);
endinterface

// file: rtl/pba_host.sv
// Host end of the PCI link: an initiator that runs one user request at a time.
// Assumes the device end on pba_if.host and that this end drives the link reset.
`timescale 1ns/1ps
`include "pba_params.svh"
module pba_host (
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        CE,
	pba_if.host              p,
	input  wire logic        REQ_VALID,
	output logic             REQ_READY,
	input  wire logic [3:0]  REQ_CMD,
	input  wire logic [31:0] REQ_ADDR,
	input  wire logic [3:0]  REQ_BE,
	input  wire logic [31:0] REQ_WDATA,
	input  wire logic [2:0]  REQ_LEN,
	input  wire logic        REQ_IDSEL,
	output logic             RSP_VALID,
	output logic [31:0]      RSP_DATA,
	output logic             DONE,
	output logic [2:0]       DONE_STAT
);
	import pba_pkg::*;

	pba_hst_s q;
	pba_hst_s n;

	assign p.hd      = q.hd;
	assign p.rst_n   = q.rst_n;
	assign p.idsel   = q.idsel_o;
	assign REQ_READY = q.rdy;
	assign RSP_VALID = q.rsp_v;
	assign RSP_DATA  = q.rsp_d;
	assign DONE      = q.done;
	assign DONE_STAT = q.stat;

	always_comb begin
		pba_bus_s b;
		logic     comp;
		logic     quit;
		n       = q;
		b       = q.s2;
		comp    = 1'b0;
		quit    = 1'b0;
		n.s1    = p.bus;
		n.s2    = q.s1;
		n.clk_q = q.s2.clk;
		n.rst_n = 1'b1;
		n.rsp_v = 1'b0;
		n.done  = 1'b0;
		if (q.rdy && REQ_VALID) begin
			n.rdy   = 1'b0;
			n.cmd   = REQ_CMD;
			n.addr  = REQ_ADDR;
			n.be    = REQ_BE;
			n.wdata = REQ_WDATA;
			n.left  = (REQ_LEN == 3'h0) ? 3'h1 : REQ_LEN;
			n.idsel = REQ_IDSEL;
			n.stat  = 3'h0;
		end
		if (b.clk && !q.clk_q) begin
			n.hd.ctl_o[`PBA_PAR]    = ^q.hd.ad_o;
			n.hd.ctl_oe_n[`PBA_PAR] = q.hd.ad_oe_n;
			n.data_chk = 1'b0;
			n.perr_st  = (q.perr_st == 2'h1) ? 2'h2 : 2'h0;
			if (q.data_chk && ^{q.ad_q, b.ctl[`PBA_PAR]}) begin
				n.perr_st            = 2'h1;
				n.stat[`PBA_ST_PERR] = 1'b1;
			end
			unique case (q.st)
				M_IDLE: begin
					if (!q.rdy && b.ctl[`PBA_FRAME] && b.ctl[`PBA_IRDY]) begin
						n.st                      = M_ADDR;
						n.hd.ctl_o[`PBA_FRAME]    = 1'b0;
						n.hd.ctl_oe_n[`PBA_FRAME] = 1'b0;
						n.hd.ctl_o[`PBA_IRDY]     = 1'b1;
						n.hd.ctl_oe_n[`PBA_IRDY]  = 1'b0;
						n.hd.ad_o                 = q.addr;
						n.hd.ad_oe_n              = 1'b0;
						n.hd.cbe_o                = q.cmd;
						n.hd.cbe_oe_n             = 1'b0;
						n.idsel_o                 = q.idsel;
					end
				end
				M_ADDR: begin
					n.st                   = M_DATA;
					n.idsel_o              = 1'b0;
					n.hd.cbe_o             = q.be;
					n.hd.ctl_o[`PBA_IRDY]  = 1'b0;
					n.hd.ctl_o[`PBA_FRAME] = (q.left == 3'h1);
					n.hd.ad_o              = q.wdata;
					n.hd.ad_oe_n           = !q.cmd[0];
					n.cnt                  = 3'h0;
					n.dsel                 = 1'b0;
				end
				M_DATA: begin
					n.dsel = q.dsel || !b.ctl[`PBA_DEVSEL];
					if (!n.dsel) begin
						n.cnt = q.cnt + 3'h1;
					end
					comp = !b.ctl[`PBA_IRDY] && !b.ctl[`PBA_TRDY];
					quit = !b.ctl[`PBA_STOP] || (!n.dsel && (n.cnt == `PBA_ABORT_CLKS));
					if (!b.ctl[`PBA_STOP]) begin
						n.stat[`PBA_ST_STOP] = 1'b1;
					end else if (quit) begin
						n.stat[`PBA_ST_ABORT] = 1'b1;
					end
					if (comp) begin
						n.left  = q.left - 3'h1;
						n.wdata = q.wdata + 32'h1;
						if (q.cmd[0]) begin
							n.hd.ad_o = n.wdata;
						end else begin
							n.rsp_v    = 1'b1;
							n.rsp_d    = b.ad;
							n.ad_q     = b.ad;
							n.data_chk = 1'b1;
						end
					end
					// Frame is released before ready, so the last phase is always visible.
					if ((comp || quit) && q.hd.ctl_o[`PBA_FRAME]) begin
						n.st                  = M_TURN;
						n.hd.ctl_o[`PBA_IRDY] = 1'b1;
						n.hd.ad_oe_n          = 1'b1;
						n.hd.cbe_oe_n         = 1'b1;
					end else if (quit) begin
						n.hd.ctl_o[`PBA_FRAME] = 1'b1;
					end else if (comp) begin
						n.hd.ctl_o[`PBA_FRAME] = (n.left == 3'h1);
					end
				end
				M_TURN: begin
					n.st                      = M_IDLE;
					n.hd.ctl_oe_n[`PBA_FRAME] = 1'b1;
					n.hd.ctl_oe_n[`PBA_IRDY]  = 1'b1;
					n.done                    = 1'b1;
					n.rdy                     = 1'b1;
				end
			endcase
			n.hd.ctl_oe_n[`PBA_PERR] = (n.perr_st == 2'h0);
			n.hd.ctl_o[`PBA_PERR]    = (n.perr_st != 2'h1);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			q     <= '0;
			q.hd  <= `PBA_DRV_OFF;
			q.rdy <= 1'b1;
		end else if (CE) begin
			q <= n;
		end
	end
endmodule

// file: test/pba_chk.sv
// Link assertions for the joined host and device ends.
// Assumes the shared link signals, judged at rising edges of the link clock.
`timescale 1ns/1ps
module pba_chk (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              idsel,
	input wire pba_pkg::pba_drv_s hd,
	input wire pba_pkg::pba_drv_s dd,
	input wire pba_pkg::pba_bus_s bus
);
	import pba_pkg::*;
	logic fr, ir, tr, sp, ds;
	// Frame, ready, stop and select are low active; a released lane reads one.
	assign {ds, sp, tr, ir, fr} = bus.ctl[5:1];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_par; !hd.ad_oe_n || !dd.ad_oe_n |=> bus.ctl[0] == $past(^bus.ad); endproperty
	a_par: assert property (p_par) else $error("parity lane wrong");
	property p_one; !(!hd.ad_oe_n && !dd.ad_oe_n) && !(!hd.ctl_oe_n[0] && !dd.ctl_oe_n[0]);
	endproperty
	a_one: assert property (p_one) else $error("two drivers on data lanes");
	property p_adr; $fell(fr) |-> !hd.ad_oe_n && !hd.cbe_oe_n && dd.ad_oe_n; endproperty
	a_adr: assert property (p_adr) else $error("address phase not driven by host");
	property p_cfg; $fell(fr) && bus.cbe[3:1] == 3'h5 && idsel |=> !ds; endproperty
	a_cfg: assert property (p_cfg) else $error("configuration access not claimed");
	property p_none; $fell(fr) && bus.cbe[3:1] == 3'h5 && !idsel |=> ds [*5]; endproperty
	a_none: assert property (p_none) else $error("unselected access claimed");
	// One target wait clock sits between the claim and the first ready.
	property p_rdy; $fell(ds) |=> tr ##1 !tr; endproperty
	a_rdy: assert property (p_rdy) else $error("target ready late");
	property p_wait; !ir && tr && sp && !ds |=> !ir; endproperty
	a_wait: assert property (p_wait) else $error("initiator left a wait state");
	property p_last; !ir && !tr && fr |=> ir; endproperty
	a_last: assert property (p_last) else $error("transfer after last datum");
	property p_stop; !sp && !tr && !ir |-> ##[1:3] fr; endproperty
	a_stop: assert property (p_stop) else $error("stop not obeyed");
	property p_err; bus.ctl[6] && bus.ctl[7]; endproperty
	a_err: assert property (p_err) else $error("error flag on clean link");
	c_stop: cover property (!sp && !tr);
	c_abort: cover property ($fell(fr) ##1 ds [*5]);
	c_burst: cover property (!ir && !tr && !fr);
endmodule

// file: test/pci_bus_agent_signalling_tb.sv
// Bench: host and device joined on one link, a second device fed by a faulty driver.
// Assumes the design files and pba_chk are compiled before it.
`timescale 1ns/1ps
`include "pba_params.svh"
module pci_bus_agent_signalling_tb;
	import pba_pkg::*;
	logic        clk, srst, lk, rv, ri, rr, rsv, dn, ap2, dp2, dp1, ap1, bsy, bsy2;
	logic [3:0]  rc, rb;
	logic [31:0] ra, rw, rsd;
	logic [2:0]  rl, dst, st;
	logic [31:0] rd [8];
	int          failures, checks, rk, se, pe, nap, ndp, ndp1, nr, nb, nap1;
	pba_if link ();
	pba_if flt ();
	assign link.clk = lk;
	assign flt.clk = lk;
	pba_host pba_host_inst (.CLK_SYS(clk), .SRST(srst), .CE(1'b1), .p(link.host),
		.REQ_VALID(rv), .REQ_READY(rr), .REQ_CMD(rc), .REQ_ADDR(ra), .REQ_BE(rb),
		.REQ_WDATA(rw), .REQ_LEN(rl), .REQ_IDSEL(ri), .RSP_VALID(rsv), .RSP_DATA(rsd),
		.DONE(dn), .DONE_STAT(dst));
	pba_target pba_target_inst (.CLK_SYS(clk), .SRST(srst), .CE(1'b1), .p(link.dev),
		.BUSY(bsy), .ADDR_PERR(ap1), .DATA_PERR(dp1));
	pba_target pba_target_inst2 (.CLK_SYS(clk), .SRST(srst), .CE(1'b1), .p(flt.dev),
		.BUSY(bsy2), .ADDR_PERR(ap2), .DATA_PERR(dp2));
	pba_chk pba_chk_inst (.clk(link.clk), .rst_n(link.rst_n), .idsel(link.idsel),
		.hd(link.hd), .dd(link.dd), .bus(link.bus));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// The link clock is offset so its edges never meet the system clock's edges.
	initial begin
		lk = 0;
		#3.3;
		forever #62.5 lk = ~lk;
	end
	always @(posedge clk) begin
		if (dp1 === 1) ndp1++;
		if (ap1 === 1) nap1++;
		if (ap2 === 1) nap++;
		if (dp2 === 1) ndp++;
	end
	always @(posedge lk) begin
		rk++;
		if (flt.bus.ctl[7] === 0 && se == 0) se = rk;
		if (flt.bus.ctl[6] === 0 && pe == 0) pe = rk;
	end
	task report_and_stop;
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] w, input logic [2:0] l, input logic i);
		int n;
		n = 0;
		nr = 0;
		nb = 0;
		@(negedge clk);
		while (rr !== 1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (rr !== 1) begin
			failures++;
			report_and_stop();
		end
		{rc, ra, rb, rw, rl, ri} = {c, a, b, w, l, i};
		rv = 1;
		@(negedge clk);
		rv = 0;
		for (n = 0; n < 1000 && dn !== 1; n++) begin
			@(posedge clk);
			#1;
			if (rsv === 1) begin
				rd[nr] = rsd;
				nr++;
			end
			if (bsy === 1) nb++;
		end
		st = dst;
		if (dn !== 1) begin
			failures++;
			report_and_stop();
		end
	endtask
	task rise;
		@(posedge lk);
		repeat (2) @(negedge clk);
	endtask
	// One-word memory write on the faulty link, with address or data parity flipped.
	task fw(input logic ba, input logic bd);
		int a;
		se = 0;
		pe = 0;
		nap = 0;
		ndp = 0;
		rise();
		a = rk + 1;
		flt.hd = '{32'h0100_0000, 1'b0, 4'h7, 1'b0, 8'hFD, 8'hF8};
		rise();
		flt.hd = '{32'h1234_5678, 1'b0, 4'h0, 1'b0, {5'h1F, 2'b01, 1'b1 ^ ba}, 8'hF8};
		rise();
		chk(bsy2, 1);
		flt.hd.ctl_o[0] = (^32'h1234_5678) ^ bd;
		repeat (2) rise();
		flt.hd.ad_oe_n = 1;
		flt.hd.ctl_o[2] = 1;
		rise();
		flt.hd = `PBA_DRV_OFF;
		repeat (4) rise();
		chk(nap, ba);
		chk(se, ba ? a + 2 : 0);
		chk(ndp, bd);
		chk(pe, bd ? a + 5 : 0);
		chk(bsy2, 0);
	endtask
	initial begin
		srst = 1;
		rv = 0;
		{rc, ra, rb, rw, rl, ri} = '0;
		flt.rst_n = 0;
		flt.idsel = 0;
		flt.hd = `PBA_DRV_OFF;
		repeat (16) @(negedge clk);
		srst = 0;
		flt.rst_n = 1;
		repeat (40) @(negedge clk);
		xfer(4'hB, 32'hC, 4'h0, 32'hA5A5_0F0F, 3'h0, 1);
		chk(st, 0);
		chk(nb > 0, 1);
		xfer(4'hA, 32'hC, 4'h0, 32'h0, 3'h0, 1);
		chk(rd[0], 32'hA5A5_0F0F);
		chk(nr, 1);
		xfer(4'hA, 32'hC, 4'h0, 32'h0, 3'h0, 0);
		chk(st, 3'h2);
		chk(nb, 0);
		xfer(4'h7, 32'h0100_0000, 4'h0, 32'h1122_3344, 3'h0, 0);
		xfer(4'h7, 32'h0100_0000, 4'hC, 32'hAABB_CCDD, 3'h0, 0);
		xfer(4'h6, 32'h0100_0000, 4'h0, 32'h0, 3'h0, 0);
		chk(rd[0], 32'h1122_CCDD);
		xfer(4'h7, 32'h0100_0038, 4'h0, 32'h5000_0000, 3'h3, 0);
		chk(st, 3'h1);
		xfer(4'h6, 32'h0100_0038, 4'h0, 32'h0, 3'h3, 0);
		chk(nr, 2);
		chk(rd[0], 32'h5000_0000);
		chk(rd[1], 32'h5000_0001);
		chk(st, 3'h1);
		xfer(4'h1, 32'h0, 4'h0, 32'h0, 3'h0, 0);
		chk(st, 3'h2);
		chk(ndp1, 0);
		chk(nap1, 0);
		srst = 1;
		repeat (16) @(negedge clk);
		srst = 0;
		repeat (40) @(negedge clk);
		xfer(4'h6, 32'h0100_0000, 4'h0, 32'h0, 3'h0, 0);
		chk(rd[0], 32'h0);
		fw(1, 0);
		fw(0, 1);
		report_and_stop();
	end
endmodule
